// >>> src/irc_pkg.sv
// Purpose: Constants and types for the input reference conditioning block.
// Assumes: 20 MHz system clock, APB register access with 32-bit data.
// Notes: Byte addresses below are the APB register offsets.
// Behaviour
// - Loop mode field: 000 auto, 001 free-run, 010 holdover, 100 locked.
// - Third loop leaves reset powered down; software clears power-down.
// - Auto mode state changes on reset, selection, loss, disqualify, reselect.
// - Free-run output uses system clock only, ignoring all references.
// - Locked output follows the selected reference's frequency.
// - Average select zero holds integral value from just before holdover.
// - Average select one holds a filtered average, about 1.2 mHz wide.
// - Output frequency offset is clamped to the programmed hard limit.
// - Each input has a 4-bit selector naming its sync pulse pin.
// - Target code decode: 8k, T1/E1, 6.48M, 2k, 4k, 1PPS, 6.25M.
// - Inputs one to four have divide-by-4 or 5 or bypass stage.
// - Integer divider is used only when the direct-divide or lock-to-8k bit is set.
// - Integer divider divides by programmed value plus one.
// - Fractional divider divides by numerator over denominator.
// - Monitoring runs on all six inputs; qualified ones offered to loops.
// - Per-input bucket: +1 per drifting 128 ms window, -1 per decay.
// - Four bucket sets; each input picks one with a 2-bit selector.
// - Bucket saturates at size; alarm above upper, clear below lower.
// - Size and thresholds are 8 bits, decay rate is 2 bits.
// - Inactive alarm shows in status and excludes input from selection.
// - Severe offset alarm excludes input; soft alarm does not.
package irc_pkg;
  localparam int NIN = 6;
  localparam int NHF = 4;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_LIMIT = 8'h08;
  localparam logic [7:0] A_FREQ = 8'h0C;
  localparam logic [7:0] A_INCFG = 8'h10;
  localparam logic [7:0] A_DIV = 8'h28;
  localparam logic [7:0] A_FEC = 8'h40;
  localparam logic [7:0] A_BKT = 8'h60;
  localparam logic [2:0] MODE_AUTO = 3'h0;
  localparam logic [2:0] MODE_FREE = 3'h1;
  localparam logic [2:0] MODE_HOLD = 3'h2;
  localparam logic [2:0] MODE_LOCK = 3'h4;
  localparam int C_PDN = 3;
  localparam int C_AVG = 4;
  localparam logic [6:0] CTRL_RST = 7'h08;
  localparam int F_DIRECT = 6;
  localparam int F_L8K = 7;
  localparam int F_STD = 14;
  localparam logic [3:0] T_8K = 4'h0;
  localparam logic [3:0] T_T1E1 = 4'h1;
  localparam logic [3:0] T_648 = 4'h2;
  localparam logic [3:0] T_2K = 4'h9;
  localparam logic [3:0] T_4K = 4'hA;
  localparam logic [3:0] T_PPS = 4'hB;
  localparam logic [3:0] T_625 = 4'hC;
  localparam logic [1:0] HF_DIV4 = 2'h1;
  localparam logic [1:0] HF_DIV5 = 2'h2;
  localparam logic [2:0] HF4_LAST = 3'h3;
  localparam logic [2:0] HF5_LAST = 3'h4;
  localparam int BKT_W = 26;
  localparam int CLK_HZ = 20_000_000;
  localparam int WINDOW_MS = 128;
  localparam int WINDOW_CYC = CLK_HZ / 1000 * WINDOW_MS;
  localparam int DRIFT_PPM = 500;
  localparam int EXP_2K = 2000 * WINDOW_MS / 1000;
  localparam int EXP_4K = 4000 * WINDOW_MS / 1000;
  localparam int EXP_8K = 8000 * WINDOW_MS / 1000;
  localparam int TOL = EXP_8K * DRIFT_PPM / 1_000_000;
  localparam int AVG_SHIFT = 10;
  localparam logic [15:0] LIMIT_RST = 16'h7FFF;
  typedef enum logic [1:0] {ST_FREE, ST_HOLD, ST_LOCK} irc_loop_st_t;
endpackage : irc_pkg

// >>> src/irc_bucket_mem.sv
// Purpose: Storage for the four leaky bucket configuration sets.
// Assumes: One write port and one registered read port on clk.
// Notes: Sets clear to zero at reset, so no input alarms until programmed.
`timescale 1ns/1ps
`default_nettype none
module irc_bucket_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire logic [irc_pkg::BKT_W-1:0] wdata,
  input wire logic [1:0] raddr,
  output logic [irc_pkg::BKT_W-1:0] rdata
);
  typedef struct packed {
    logic [3:0][irc_pkg::BKT_W-1:0] mem;
    logic [irc_pkg::BKT_W-1:0] rdata;
  } irc_mem_state_t;
  irc_mem_state_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.rdata = s_q.mem[raddr];
    if (we) begin
      s_d.mem[waddr] = wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign rdata = s_q.rdata;
endmodule : irc_bucket_mem
`default_nettype wire

// >>> src/irc_top.sv
// Purpose: Input pre-dividers, sync selection, activity monitoring and
//   third loop mode control, reached over APB.
// Assumes: Severe offset flags, selection and integral come from logic
//   on clk; reference pins are asynchronous and pass two flip-flops.
// Notes: References must be slower than a quarter of clk to be counted.
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module irc_top #(
  parameter int WINDOW_CYCLES = irc_pkg::WINDOW_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] ref_pin,
  input wire logic [5:0] input_offset_severe_flag,
  input wire logic [2:0] third_loop_selected,
  input wire logic [15:0] third_loop_integral,
  output logic [5:0] input_qualified,
  output logic [5:0] input_inactive_flag,
  output logic [5:0] prediv_pulse,
  output logic [5:0] sync_pulse,
  output logic [15:0] third_loop_freq,
  output logic [1:0] third_loop_state,
  output logic third_loop_power_down
);
  typedef struct packed {
    logic [5:0] p1, p2, p3;
    logic [6:0] ctrl;
    logic [15:0] limit;
    logic [5:0][14:0] cfg;
    logic [5:0][7:0] div_lo;
    logic [5:0][14:0] div;
    logic [5:0][31:0] fec;
    logic [3:0][2:0] hf_cnt;
    logic [5:0][15:0] fec_acc;
    logic [5:0][14:0] dn_cnt;
    logic [5:0][10:0] ev_cnt;
    logic [5:0] ev_hit;
    logic [5:0][7:0] bkt;
    logic [5:0][2:0] dec_cnt;
    logic [5:0] inact, qual, pdiv, spul;
    logic [21:0] win;
    logic walk;
    logic [2:0] widx;
    logic rd_pend, pready, pslverr;
    logic [31:0] prdata;
    irc_pkg::irc_loop_st_t lst;
    logic [2:0] lsel;
    logic [15:0] freq, held;
    logic [31:0] avg;
  } irc_state_t;

  irc_state_t s_q, s_d;
  logic [irc_pkg::BKT_W-1:0] mem_rdata;
  logic mem_we;
  logic [1:0] mem_raddr;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Returns the expected event count per window, or zero when the code
  // gives no countable rate.
  function automatic logic [10:0] expected(input logic [3:0] code);
    logic [10:0] e;
    e = '0;
    unique case (code)
      irc_pkg::T_2K: e = 11'(irc_pkg::EXP_2K);
      irc_pkg::T_4K: e = 11'(irc_pkg::EXP_4K);
      irc_pkg::T_8K: e = 11'(irc_pkg::EXP_8K);
      default: e = '0;
    endcase
    return e;
  endfunction : expected

  // Known but uncountable rates only fail when wholly silent; a one pulse
  // per second input cannot be judged inside one window.
  function automatic logic drifted(input logic [3:0] code,
      input logic [10:0] cnt);
    logic [10:0] e;
    logic [10:0] d;
    logic r;
    e = expected(code);
    d = (cnt > e) ? 11'(cnt - e) : 11'(e - cnt);
    r = 1'b0;
    if (e != '0) begin
      r = d > 11'(irc_pkg::TOL);
    end else if (code != irc_pkg::T_PPS) begin
      r = cnt == '0;
    end
    return r;
  endfunction : drifted

  function automatic logic code_ok(input logic [3:0] code);
    return code inside {irc_pkg::T_8K, irc_pkg::T_T1E1, irc_pkg::T_648,
      irc_pkg::T_2K, irc_pkg::T_4K, irc_pkg::T_PPS, irc_pkg::T_625};
  endfunction : code_ok

  irc_bucket_mem u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .we(mem_we),
    .waddr(paddr[3:2]),
    .wdata(pwdata[irc_pkg::BKT_W-1:0]),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  logic acc, bkt_hit;
  logic [5:0] edges, e1;
  assign acc = psel & penable;
  assign bkt_hit = paddr[7:4] == irc_pkg::A_BKT[7:4];
  assign mem_we = s_q.pready & acc & pwrite & bkt_hit;

  always_comb begin
    mem_raddr = paddr[3:2];
    for (int k = 0; k < irc_pkg::NIN; k++) begin
      if (s_q.walk && s_q.widx == 3'(k)) begin
        mem_raddr = s_q.cfg[k][9:8];
      end
    end
  end

  always_comb begin
    logic [16:0] sum;
    logic e2, e3, hit, tick, sel_ok;
    logic [31:0] rv;
    logic [7:0] size, up, lo, nb;
    logic [2:0] dl;
    logic [15:0] raw;
    logic [31:0] tgt;
    s_d = s_q;
    sum = '0;
    e2 = 1'b0;
    e3 = 1'b0;
    hit = 1'b0;
    rv = '0;
    size = mem_rdata[7:0];
    up = mem_rdata[15:8];
    lo = mem_rdata[23:16];
    nb = '0;
    dl = 3'(4'h1 << mem_rdata[25:24]) - 3'h1;
    raw = '0;
    tgt = '0;
    tick = 1'b0;
    sel_ok = 1'b0;
    s_d.p1 = ref_pin;
    s_d.p2 = s_q.p1;
    s_d.p3 = s_q.p2;
    edges = s_q.p2 & ~s_q.p3;
    tick = s_q.win == 22'(WINDOW_CYCLES - 1);
    s_d.win = tick ? '0 : s_q.win + 22'h1;

    e1 = edges;
    for (int i = 0; i < irc_pkg::NHF; i++) begin
      if (edges[i] && s_q.cfg[i][5:4] inside {irc_pkg::HF_DIV4,
          irc_pkg::HF_DIV5}) begin
        e1[i] = s_q.hf_cnt[i] == ((s_q.cfg[i][5:4] == irc_pkg::HF_DIV4) ?
          irc_pkg::HF4_LAST : irc_pkg::HF5_LAST);
        s_d.hf_cnt[i] = e1[i] ? '0 : s_q.hf_cnt[i] + 3'h1;
      end else if (edges[i]) begin
        e1[i] = 1'b1;
      end
    end

    for (int i = 0; i < irc_pkg::NIN; i++) begin
      e2 = e1[i];
      if (e1[i] && s_q.fec[i][15:0] != '0 && s_q.fec[i][31:16] != '0) begin
        sum = {1'b0, s_q.fec_acc[i]} + {1'b0, s_q.fec[i][31:16]};
        e2 = sum >= {1'b0, s_q.fec[i][15:0]};
        s_d.fec_acc[i] = e2 ? 16'(sum - {1'b0, s_q.fec[i][15:0]})
          : sum[15:0];
      end
      e3 = e2;
      if (s_q.cfg[i][irc_pkg::F_DIRECT] || s_q.cfg[i][irc_pkg::F_L8K]) begin
        e3 = 1'b0;
        if (e2) begin
          e3 = s_q.dn_cnt[i] >= s_q.div[i];
          s_d.dn_cnt[i] = e3 ? '0 : s_q.dn_cnt[i] + 15'h1;
        end
      end
      s_d.pdiv[i] = e3;
      if (e3 && s_q.ev_cnt[i] != '1) begin
        s_d.ev_cnt[i] = s_q.ev_cnt[i] + 11'h1;
      end
      if (tick) begin
        s_d.ev_hit[i] = drifted(s_q.cfg[i][3:0], s_q.ev_cnt[i]);
        s_d.ev_cnt[i] = '0;
      end
      s_d.spul[i] = 1'b0;
      for (int j = 0; j < irc_pkg::NIN; j++) begin
        if (s_q.cfg[i][13:10] == 4'(j + 1) && edges[j]) begin
          s_d.spul[i] = 1'b1;
        end
      end
      s_d.qual[i] = ~s_q.inact[i] & ~input_offset_severe_flag[i];
    end

    // The sets sit in a memory with one read port, so the window result is applied
    // one input per cycle; the read lags its address by one cycle.
    if (tick) begin
      s_d.walk = 1'b1;
      s_d.widx = '0;
    end else if (s_q.walk) begin
      s_d.widx = s_q.widx + 3'h1;
      s_d.walk = s_q.widx != 3'(irc_pkg::NIN);
      for (int k = 0; k < irc_pkg::NIN; k++) begin
        if (s_q.widx == 3'(k + 1)) begin
          nb = s_q.bkt[k];
          if (s_q.ev_hit[k]) begin
            nb = (nb < size) ? nb + 8'h1 : size;
            s_d.dec_cnt[k] = '0;
          end else if (s_q.dec_cnt[k] >= dl) begin
            nb = (nb > size) ? size : ((nb != '0) ? nb - 8'h1 : nb);
            s_d.dec_cnt[k] = '0;
          end else begin
            s_d.dec_cnt[k] = s_q.dec_cnt[k] + 3'h1;
          end
          s_d.bkt[k] = nb;
          if (nb > up) begin
            s_d.inact[k] = 1'b1;
          end else if (nb < lo) begin
            s_d.inact[k] = 1'b0;
          end
        end
      end
    end

    rv = '0;
    hit = 1'b1;
    unique case (paddr)
      irc_pkg::A_CTRL: rv = 32'(s_q.ctrl);
      irc_pkg::A_STAT: begin
        for (int i = 0; i < irc_pkg::NIN; i++) begin
          rv[16 + i] = ~code_ok(s_q.cfg[i][3:0]);
        end
        rv[15:0] = {2'h0, s_q.lst, s_q.qual, s_q.inact};
      end
      irc_pkg::A_LIMIT: rv = 32'(s_q.limit);
      irc_pkg::A_FREQ: rv = 32'(s_q.freq);
      default: begin
        hit = 1'b0;
        for (int i = 0; i < irc_pkg::NIN; i++) begin
          if (paddr == irc_pkg::A_INCFG + 8'(4 * i)) begin
            rv = 32'(s_q.cfg[i]);
            hit = 1'b1;
          end
          if (paddr == irc_pkg::A_DIV + 8'(4 * i)) begin
            rv = 32'(s_q.div[i]);
            hit = 1'b1;
          end
          if (paddr == irc_pkg::A_FEC + 8'(4 * i)) begin
            rv = s_q.fec[i];
            hit = 1'b1;
          end
        end
        hit = hit | bkt_hit;
      end
    endcase

    if (s_q.pready) begin
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      if (acc && pwrite && hit) begin
        if (paddr == irc_pkg::A_CTRL) begin
          s_d.ctrl = 7'(merge(32'(s_q.ctrl), pwdata, pstrb));
        end
        if (paddr == irc_pkg::A_LIMIT) begin
          s_d.limit = 16'(merge(32'(s_q.limit), pwdata, pstrb));
        end
        for (int i = 0; i < irc_pkg::NIN; i++) begin
          if (paddr == irc_pkg::A_INCFG + 8'(4 * i)) begin
            s_d.cfg[i] = 15'(merge(32'(s_q.cfg[i]), pwdata, pstrb));
          end
          if (paddr == irc_pkg::A_FEC + 8'(4 * i)) begin
            s_d.fec[i] = merge(s_q.fec[i], pwdata, pstrb);
          end
          if (paddr == irc_pkg::A_DIV + 8'(4 * i)) begin
            if (pstrb[0]) begin
              s_d.div_lo[i] = pwdata[7:0];
            end
            if (pstrb[1]) begin
              s_d.div[i] = {pwdata[14:8],
                pstrb[0] ? pwdata[7:0] : s_q.div_lo[i]};
            end
          end
        end
      end
    end else if (acc) begin
      if (s_q.rd_pend) begin
        s_d.rd_pend = 1'b0;
        s_d.pready = 1'b1;
        s_d.prdata = 32'(mem_rdata);
      end else if (!pwrite && bkt_hit) begin
        s_d.rd_pend = !s_q.walk;
      end else begin
        s_d.pready = 1'b1;
        s_d.pslverr = !hit;
        // A refused write must not echo the last read word.
        s_d.prdata = (pwrite && hit) ? s_q.prdata : rv;
      end
    end

    sel_ok = 1'b0;
    for (int i = 0; i < irc_pkg::NIN; i++) begin
      if (third_loop_selected == 3'(i + 1)) begin
        sel_ok = s_q.qual[i];
      end
    end
    s_d.lsel = third_loop_selected;
    if (s_q.ctrl[irc_pkg::C_PDN]) begin
      s_d.lst = irc_pkg::ST_FREE;
    end else begin
      unique case (s_q.ctrl[2:0])
        irc_pkg::MODE_FREE: s_d.lst = irc_pkg::ST_FREE;
        irc_pkg::MODE_HOLD: s_d.lst = irc_pkg::ST_HOLD;
        irc_pkg::MODE_LOCK: s_d.lst = irc_pkg::ST_LOCK;
        irc_pkg::MODE_AUTO: begin
          unique case (s_q.lst)
            irc_pkg::ST_FREE: if (sel_ok) begin
              s_d.lst = irc_pkg::ST_LOCK;
            end
            irc_pkg::ST_LOCK: begin
              if (!sel_ok || third_loop_selected != s_q.lsel) begin
                s_d.lst = irc_pkg::ST_HOLD;
              end
            end
            irc_pkg::ST_HOLD: begin
              if (sel_ok) begin
                s_d.lst = irc_pkg::ST_LOCK;
              end else if (third_loop_selected == '0) begin
                s_d.lst = irc_pkg::ST_FREE;
              end
            end
            default: s_d.lst = irc_pkg::ST_FREE;
          endcase
        end
        default: s_d.lst = s_q.lst;
      endcase
    end

    if (s_q.lst == irc_pkg::ST_LOCK) begin
      s_d.held = third_loop_integral;
      if (tick) begin
        tgt = {third_loop_integral, 16'h0000};
        s_d.avg = s_q.avg + 32'(($signed(tgt) - $signed(s_q.avg))
          >>> irc_pkg::AVG_SHIFT);
      end
    end
    unique case (s_q.lst)
      irc_pkg::ST_LOCK: raw = third_loop_integral;
      irc_pkg::ST_HOLD: raw = s_q.ctrl[irc_pkg::C_AVG] ? s_q.avg[31:16]
        : s_q.held;
      default: raw = '0;
    endcase
    if ($signed(raw) > $signed(s_q.limit)) begin
      raw = s_q.limit;
    end else if ($signed(raw) < -$signed(s_q.limit)) begin
      raw = 16'(-$signed(s_q.limit));
    end
    s_d.freq = s_q.ctrl[irc_pkg::C_PDN] ? '0 : raw;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.ctrl <= irc_pkg::CTRL_RST;
      s_q.limit <= irc_pkg::LIMIT_RST;
      s_q.lst <= irc_pkg::ST_FREE;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign input_qualified = s_q.qual;
  assign input_inactive_flag = s_q.inact;
  assign prediv_pulse = s_q.pdiv;
  assign sync_pulse = s_q.spul;
  assign third_loop_freq = s_q.freq;
  assign third_loop_state = s_q.lst;
  assign third_loop_power_down = s_q.ctrl[irc_pkg::C_PDN];
endmodule : irc_top
`default_nettype wire

// >>> sim/irc_ref_src.sv
// Purpose: Reference clock sources for the six input pins.
// Assumes: Pin i toggles every 3+i cycles, so every pin is slower than clk/4.
// Notes: A stopped source freezes its level, as a dead reference would.
`timescale 1ns/1ps
`default_nettype none
module irc_ref_src (
  input wire logic clk,
  input wire logic [5:0] run,
  output logic [5:0] ref_pin
);
  int cnt [6] = '{default: 0};
  initial ref_pin = 6'h00;
  always @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      if (!run[i]) begin
        cnt[i] <= 0;
      end else if (cnt[i] == 2 + i) begin
        cnt[i] <= 0;
        ref_pin[i] <= ~ref_pin[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule : irc_ref_src
`default_nettype wire

// >>> sim/irc_top_chk.sv
// Purpose: Port-level assertions on the conditioning block.
// Assumes: One clock domain; the APB master holds requests until pready.
// Notes: Qualified status is judged one cycle behind the alarms.
`timescale 1ns/1ps
`default_nettype none
module irc_top_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] input_offset_severe_flag,
  input wire logic [5:0] input_qualified,
  input wire logic [5:0] input_inactive_flag,
  input wire logic [5:0] prediv_pulse,
  input wire logic [5:0] sync_pulse,
  input wire logic [15:0] third_loop_freq,
  input wire logic [1:0] third_loop_state,
  input wire logic third_loop_power_down
);
  logic up_q;
  always_ff @(posedge clk) begin
    up_q <= rst_n;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_apb_wait: assert property (psel && !penable && paddr < 8'h58
    |=> !pready ##1 pready) else $error("register answer late");
  chk_bkt_wait: assert property (
    psel && !penable && !pwrite && paddr[7:4] == 4'h6
    |=> !pready ##1 !pready ##[1:8] pready)
    else $error("bucket read answer late");
  chk_err_unmap: assert property (pready && paddr >= 8'h70 |-> pslverr)
    else $error("unmapped access not refused");
  chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused access returned data");
  chk_pdn_clear: assert property ($fell(third_loop_power_down) |->
    $past(psel && penable && pready && pwrite && paddr == 8'h00))
    else $error("power-down left without a control write");
  chk_pdn_quiet: assert property (
    $past(third_loop_power_down) && third_loop_power_down
    |-> third_loop_state == 2'h0 && third_loop_freq == 16'h0)
    else $error("powered-down loop not in free-run at zero");
  chk_qual_excl: assert property (up_q |-> input_qualified ==
    (~$past(input_inactive_flag) & ~$past(input_offset_severe_flag)))
    else $error("qualified inputs disagree with alarms");
  chk_pulse_gap: assert property (
    ((prediv_pulse & $past(prediv_pulse)) |
     (sync_pulse & $past(sync_pulse))) == 6'h00)
    else $error("pin pulse lasted two cycles");
  cover property (third_loop_state == 2'h2);
  cover property ($rose(input_inactive_flag[0]));
  cover property (pslverr);
endmodule : irc_top_chk
bind irc_top irc_top_chk u_irc_top_chk (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .input_offset_severe_flag(input_offset_severe_flag),
  .input_qualified(input_qualified),
  .input_inactive_flag(input_inactive_flag), .prediv_pulse(prediv_pulse),
  .sync_pulse(sync_pulse), .third_loop_freq(third_loop_freq),
  .third_loop_state(third_loop_state),
  .third_loop_power_down(third_loop_power_down));
`default_nettype wire

// >>> sim/input_ref_conditioning_test.sv
// Purpose: Self-checking bench for the conditioning block over APB.
// Assumes: Window shortened to 200 cycles; pins come from irc_ref_src.
// Notes: Edge counts allow one pulse of slack for divider phase.
`timescale 1ns/1ps
`default_nettype none
module input_ref_conditioning_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic [5:0] ref_pin, qual, inact, pdiv, syncp, prev;
  logic [5:0] sev = 6'h00, run = 6'h1E;
  logic [2:0] sel = 3'h0;
  logic [15:0] integ = 16'h0, freq;
  logic [1:0] state;
  logic pdn;
  int num_errors = 0, checks_done = 0, nsync;
  int rises [6], pulses [6];
  initial begin
    forever #25 clk = ~clk;
  end
  irc_top #(.WINDOW_CYCLES(200)) u_irc_top (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_pin(ref_pin), .input_offset_severe_flag(sev),
    .third_loop_selected(sel), .third_loop_integral(integ),
    .input_qualified(qual), .input_inactive_flag(inact),
    .prediv_pulse(pdiv), .sync_pulse(syncp), .third_loop_freq(freq),
    .third_loop_state(state), .third_loop_power_down(pdn));
  irc_ref_src u_irc_ref_src (.clk(clk), .run(run), .ref_pin(ref_pin));
  task close_out;
    $display("comparisons %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s: saw %h want %h", $time, m, seen, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      chk(32'h0, 32'h1, "no pready");
    end
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr
  task settle;
    repeat (3) @(posedge clk);
  endtask : settle
  task count(input int n);
    rises = '{default: 0};
    pulses = '{default: 0};
    nsync = 0;
    prev = ref_pin;
    repeat (n) begin
      @(posedge clk);
      for (int i = 0; i < 6; i++) begin
        rises[i] += int'(ref_pin[i] & ~prev[i]);
        pulses[i] += int'(pdiv[i]);
      end
      nsync += int'(syncp[0]);
      prev = ref_pin;
    end
  endtask : count
  function automatic logic [31:0] near(input int p, input int r, input int d);
    return {31'h0, p >= r / d - 1 && p <= r / d + 1};
  endfunction : near
  task mode(input logic [2:0] m, input logic [1:0] st, input string t);
    wr(irc_pkg::A_CTRL, {29'h0, m});
    settle();
    chk({30'h0, state}, {30'h0, st}, t);
  endtask : mode
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({31'h0, pdn}, 32'h1, "power-down at reset");
    apb(1'b0, irc_pkg::A_CTRL, 32'h0, 4'h0);
    chk(rd, {25'h0, irc_pkg::CTRL_RST}, "ctrl reset");
    apb(1'b0, irc_pkg::A_LIMIT, 32'h0, 4'h0);
    chk(rd, {16'h0, irc_pkg::LIMIT_RST}, "limit reset");
    $display("test reset done");
    sel <= 3'h1;
    integ <= 16'h0123;
    mode(irc_pkg::MODE_LOCK, 2'h2, "forced locked");
    chk({16'h0, freq}, 32'h0123, "locked follows");
    mode(irc_pkg::MODE_HOLD, 2'h1, "forced holdover");
    integ <= 16'h0456;
    settle();
    chk({16'h0, freq}, 32'h0123, "holdover value");
    mode(irc_pkg::MODE_FREE, 2'h0, "forced free");
    chk({16'h0, freq}, 32'h0, "free ignores refs");
    mode(3'h3, 2'h0, "reserved code");
    mode(irc_pkg::MODE_AUTO, 2'h2, "auto locks");
    chk({16'h0, freq}, 32'h0456, "auto follows");
    sev <= 6'h01;
    settle();
    chk({26'h0, qual}, 32'h3E, "severe excluded");
    chk({30'h0, state}, 32'h1, "disqualify holds");
    sel <= 3'h0;
    settle();
    chk({30'h0, state}, 32'h0, "no selection");
    sev <= 6'h00;
    sel <= 3'h2;
    integ <= 16'h0500;
    wr(irc_pkg::A_LIMIT, 32'h0100);
    settle();
    chk({16'h0, freq}, 32'h0100, "upper clamp");
    integ <= 16'hFB00;
    settle();
    apb(1'b0, irc_pkg::A_FREQ, 32'h0, 4'h0);
    chk(rd, 32'hFF00, "lower clamp");
    wr(irc_pkg::A_CTRL, 32'h08);
    settle();
    chk({14'h0, state, freq}, 32'h0, "powered down");
    $display("test modes done");
    wr(8'h14, 32'h42);
    wr(8'h18, 32'h12);
    wr(8'h1C, 32'h02);
    wr(8'h4C, 32'h0001_0003);
    wr(8'h10, 32'h0902);
    wr(8'h20, 32'h09);
    apb(1'b1, 8'h2C, 32'h04, 4'h1);
    count(600);
    chk(near(pulses[1], rises[1], 1), 32'h1, "low byte alone");
    chk(near(pulses[2], rises[2], 4), 32'h1, "high rate /4");
    chk(near(pulses[3], rises[3], 3), 32'h1, "fraction 3/1");
    chk(near(nsync, rises[1], 1), 32'h1, "sync from pin 2");
    chk(near(pulses[4], rises[4], 1), 32'h1, "bypassed 2k");
    apb(1'b1, 8'h2C, 32'h0, 4'h2);
    wr(8'h14, 32'h82);
    wr(8'h18, 32'h22);
    count(600);
    chk(near(pulses[1], rises[1], 5), 32'h1, "divide 4+1");
    chk(near(pulses[2], rises[2], 5), 32'h1, "high rate /5");
    $display("test dividers done");
    wr(8'h64, 32'h0001_0103);
    apb(1'b0, 8'h64, 32'h0, 4'h0);
    chk(rd, 32'h0001_0103, "bucket set");
    repeat (1000) @(posedge clk);
    chk({26'h0, inact}, 32'h01, "dead input alarms");
    apb(1'b0, irc_pkg::A_STAT, 32'h0, 4'h0);
    chk({20'h0, rd[11:0]}, 32'hF81, "status bits");
    run <= 6'h0F;
    repeat (250) @(posedge clk);
    chk({31'h0, inact[0]}, 32'h1, "kept above lower");
    repeat (600) @(posedge clk);
    chk({31'h0, inact[0]}, 32'h0, "saturated then drained");
    $display("test buckets done");
    integ <= 16'h7000;
    wr(irc_pkg::A_CTRL, 32'h34);
    apb(1'b0, irc_pkg::A_CTRL, 32'h0, 4'h0);
    chk(rd, 32'h34, "sync rate field");
    repeat (600) @(posedge clk);
    wr(irc_pkg::A_CTRL, 32'h32);
    settle();
    // The average lags the step, so it sits well below the clamped value.
    chk({31'h0, freq != 16'h0 && freq < 16'h0100}, 32'h1, "avg hold");
    $display("test average done");
    apb(1'b0, 8'h70, 32'h0, 4'h0);
    chk({31'h0, er}, 32'h1, "unmapped read refused");
    chk(rd, 32'h0, "unmapped read data");
    apb(1'b1, 8'h58, 32'hFFFF_FFFF, 4'hF);
    chk({31'h0, er}, 32'h1, "gap write");
    $display("test refusals done");
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end
endmodule : input_ref_conditioning_test
`default_nettype wire
